// *** logic/bfs_pkg.sv ***
// package: register map, field layout and timing constants for the buck fault supervisor
package bfs_pkg;
    // ---------------------------------------------------------------
    // register word offsets (byte addresses)
    // ---------------------------------------------------------------
    localparam logic [7:0] bfs_reg_ctrl_ofs = 8'h00; // per buck: host enable, forced low power
    localparam logic [7:0] bfs_reg_mode_ofs = 8'h04; // power mode selects, ramp-down enable
    localparam logic [7:0] bfs_reg_mask_ofs = 8'h08; // uv/ov masks
    localparam logic [7:0] bfs_reg_flag_ofs = 8'h0c; // sticky flags, write one to clear
    localparam logic [7:0] bfs_reg_stat_ofs = 8'h10; // live status and outputs
    localparam logic [7:0] bfs_reg_seq_ofs = 8'h14; // sequencer config, one byte per buck
    localparam logic [7:0] bfs_reg_vout_ofs = 8'h18; // voltage codes, one byte per buck
    localparam logic [7:0] bfs_reg_dis_ofs = 8'h1c; // discharge disable per buck
    // ---------------------------------------------------------------
    // field layout
    // ---------------------------------------------------------------
    localparam int bfs_nbuck = 3; // buck_one, buck_two, buck_three
    localparam int bfs_seq_part_bit = 7; // takes part in the sequence
    localparam int bfs_seq_master_lsb = 4; // sequencer master, 2 bits
    localparam int bfs_seq_slot_lsb = 0; // time slot, 3 bits
    localparam int bfs_ramp_dn_bit = 8; // ramp_down_ctrl_enable in mode register
    localparam int bfs_lp_force_lsb = 4; // forced low power bits in ctrl register
    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam logic [7:0] bfs_vout_rst = 8'h00; // lowest code, 0.600 V
    localparam logic [1:0] bfs_mode_rst = 2'h1; // normal power
    // ---------------------------------------------------------------
    // voltage scale, microvolts
    // ---------------------------------------------------------------
    localparam int bfs_vmin_uv = 600000; // code zero for buck_two and buck_three
    localparam int bfs_step2_uv = 6250;
    localparam int bfs_step3_uv = 12500;
    // ---------------------------------------------------------------
    // timing: soft-start ramps at 17 mV per us
    // ---------------------------------------------------------------
    localparam int bfs_clk_mhz = 200;
    localparam int bfs_ss_uv_per_us = 17000;
    // power mode field codes
    typedef enum logic [1:0]
    {
        bfs_pm_off = 2'b00,
        bfs_pm_normal = 2'b01,
        bfs_pm_lp_sleep = 2'b10,
        bfs_pm_lp = 2'b11
    } bfs_pmode_t;
endpackage

// *** logic/bfs_blank.sv ***
// one buck's blanking window timer: soft-start and controlled downward ramp
`timescale 1ns/1ps
`default_nettype none
module bfs_blank
#(
    parameter int cnt_w = 20 // counter width in bits, counts cycles
)
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic start, // one-cycle load pulse
    input wire logic [cnt_w-1:0] len, // window length in cycles
    input wire logic abort, // drop the window at once
    output logic busy // window open
);
    // ---------------------------------------------------------------
    // down counter
    // ---------------------------------------------------------------
    logic [cnt_w-1:0] cnt; // remaining cycles

    // load on start, count to zero, abort clears
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            cnt <= '0;
        else if (abort)
            cnt <= '0;
        else if (start)
            cnt <= len;
        else if (cnt != '0)
            cnt <= cnt - 1'b1;
    end

    assign busy = (cnt != '0);

    // a started window with nonzero length opens next cycle
    a_window_opens: assert property (@(posedge clk) disable iff (!rstn)
        start && !abort && len != '0 |=> busy)
        else $error("blank window did not open");
endmodule
`default_nettype wire

// *** logic/bfs_top.sv ***
// buck fault supervisor: uv/ov flags, blanking, powerdown request, enable and mode control
`timescale 1ns/1ps
`default_nettype none
// Function
// - ramp-down enabled: hide overvoltage until ramp done
// - ramp-down disabled: overvoltage fires, unmasked powers down
// - live status bits for uv, ov, current limit
// - enable from sequencer or host write
// - sequencer config: participation, master, slot
// - two-bit power mode selects normal or low
// - optional automatic low power in deep sleep
// - host can force low power always
// - buck_two code 0.600V plus 6.25mV steps
// - buck_three code 0.600V plus 12.5mV steps
// - undervoltage comparator latches undervoltage flag
// - unmasked undervoltage requests powerdown
// - undervoltage blanked during soft-start period only
// - raising code steps target, no blanking
// - masked events still set their flags
// - overvoltage comparator latches overvoltage flag
// - unmasked overvoltage requests powerdown
// - overvoltage blanked during soft-start period
// - overvoltage after code change powers down unmasked
// - discharge on by default when regulator off
// - enabled regulator always disconnects discharge
module bfs_top
    import bfs_pkg::*;
#(
    parameter int ramp_cycles = 2000 // downward controlled ramp length
)
(
    input wire logic clk,
    input wire logic rstn,
    // avalon-mm slave
    input wire logic [7:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    // analog comparators, asynchronous
    input wire logic [bfs_nbuck-1:0] uv_cmp,
    input wire logic [bfs_nbuck-1:0] ov_cmp,
    input wire logic [bfs_nbuck-1:0] ilim_cmp,
    // sequencer side
    input wire logic [bfs_nbuck-1:0] seq_enable, // sequencer's enable per buck
    input wire logic deep_sleep_state, // chip in deep sleep
    output logic powerdown_req, // to the power sequencer
    // regulator controls
    output logic [bfs_nbuck-1:0] buck_enable,
    output logic [bfs_nbuck-1:0] buck_low_power,
    output logic [bfs_nbuck-1:0] discharge_on,
    output logic [bfs_nbuck*8-1:0] buck_voltage_code,
    output logic [bfs_nbuck*8-1:0] buck_sequencer_config,
    output logic [bfs_nbuck*22-1:0] buck_target_uv // target in microvolts
);
    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    logic [bfs_nbuck-1:0] host_en; // host enable
    logic [bfs_nbuck-1:0] lp_force; // forced low power
    logic [bfs_nbuck*2-1:0] pmode; // power mode fields
    logic ramp_down_ctrl_enable; // controlled downward ramp
    logic [bfs_nbuck-1:0] uv_mask;
    logic [bfs_nbuck-1:0] ov_mask;
    logic [bfs_nbuck-1:0] uv_flag; // sticky
    logic [bfs_nbuck-1:0] ov_flag; // sticky
    logic [bfs_nbuck-1:0] discharge_disable;
    logic [7:0] vout [bfs_nbuck]; // voltage codes
    logic [7:0] seqc [bfs_nbuck]; // sequencer configs

    // ---------------------------------------------------------------
    // bus decode
    // ---------------------------------------------------------------
    logic ack; // one-cycle answer
    logic wr_take; // write taken this edge
    logic [31:0] wmask; // byte enables spread to bits
    assign wr_take = avs_write && ack;
    assign avs_waitrequest = (avs_read || avs_write) && !ack;

    // answer every request on its second cycle, so read data can register
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            ack <= 1'b0;
        else
            ack <= (avs_read || avs_write) && !ack;
    end

    // byte enable mask
    always_comb
    begin
        for (int b = 0; b < 4; b++)
            wmask[b*8 +: 8] = {8{avs_byteenable[b]}};
    end

    // masked write helper, used by the ctrl and mode register writes and the lowered-code check
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [31:0] m);
        merge = (old & ~m) | (d & m);
    endfunction

    // ---------------------------------------------------------------
    // input synchronisers
    // ---------------------------------------------------------------
    logic [bfs_nbuck*4+1-1:0] sy1; // first stage, read only by sy2
    logic [bfs_nbuck*4+1-1:0] sy2;
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            sy1 <= '0;
            sy2 <= '0;
        end
        else
        begin
            sy1 <= {deep_sleep_state, seq_enable, ilim_cmp, ov_cmp, uv_cmp};
            sy2 <= sy1;
        end
    end
    logic [bfs_nbuck-1:0] uv_s, ov_s, ilim_s, seq_en_s;
    logic sleep_s;
    assign {sleep_s, seq_en_s, ilim_s, ov_s, uv_s} = sy2;

    // ---------------------------------------------------------------
    // per-buck control and supervision
    // ---------------------------------------------------------------
    logic [bfs_nbuck-1:0] en_prev; // enable last cycle
    logic [bfs_nbuck-1:0] ss_busy, rd_busy; // blanking windows
    logic [bfs_nbuck-1:0] uv_ev, ov_ev; // qualified events
    logic [bfs_nbuck-1:0] code_dn; // code lowered this edge

    // enable follows sequencer or host
    assign buck_enable = host_en | seq_en_s;

    genvar i;
    generate
        for (i = 0; i < bfs_nbuck; i++)
        begin : g_buck
            logic [7:0] nxt_code; // value the write will leave
            logic [19:0] ss_len; // soft-start cycles from target
            logic [21:0] tgt;
            logic [1:0] pm;
            logic ss_win; // soft-start blank, enable edge included
            assign pm = pmode[i*2 +: 2];
            assign nxt_code = 8'(merge({24'h0, vout[i]}, avs_writedata >> (8*i), wmask >> (8*i)));
            assign code_dn[i] = wr_take && avs_address == bfs_reg_vout_ofs && avs_byteenable[i]
                && nxt_code < vout[i];

            // target voltage: buck_one shares buck_two's scale here
            assign tgt = (i == 2) ? 22'(bfs_vmin_uv + int'(vout[i]) * bfs_step3_uv)
                : 22'(bfs_vmin_uv + int'(vout[i]) * bfs_step2_uv);
            assign buck_target_uv[i*22 +: 22] = tgt;
            // soft-start length = target / 17 mV/us, at 200 cycles per us
            assign ss_len = 20'((int'(tgt) * bfs_clk_mhz) / bfs_ss_uv_per_us);

            // soft-start window opens at enable, closes after a length set by the target voltage
            bfs_blank #(.cnt_w(20)) u_ss
            (
                .clk(clk),
                .rstn(rstn),
                .start(buck_enable[i] && !en_prev[i]),
                .len(ss_len),
                .abort(!buck_enable[i]),
                .busy(ss_busy[i])
            );
            // downward ramp window only when controlled ramp is on
            bfs_blank #(.cnt_w(20)) u_rd
            (
                .clk(clk),
                .rstn(rstn),
                .start(code_dn[i] && ramp_down_ctrl_enable && buck_enable[i]),
                .len(20'(ramp_cycles)),
                .abort(!buck_enable[i]),
                .busy(rd_busy[i])
            );

            // uv: blanked only by soft-start; raised code not blanked
            // the counter loads one edge after enable, so the enable cycle itself must blank too
            assign ss_win = ss_busy[i] || (buck_enable[i] && !en_prev[i]);
            assign uv_ev[i] = uv_s[i] && buck_enable[i] && !ss_win;
            // ov: blanked by soft-start and controlled ramp
            assign ov_ev[i] = ov_s[i] && buck_enable[i] && !ss_win && !rd_busy[i];

            // low power: forced, or mode field, or sleep entry
            assign buck_low_power[i] = lp_force[i] || pm == bfs_pm_lp
                || (pm == bfs_pm_lp_sleep && sleep_s);
            // discharge only while off and not disabled
            assign discharge_on[i] = !buck_enable[i] && !discharge_disable[i];
            assign buck_voltage_code[i*8 +: 8] = vout[i];
            assign buck_sequencer_config[i*8 +: 8] = seqc[i];
        end
    endgenerate

    // enable history for soft-start start edge
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            en_prev <= '0;
        else
            en_prev <= buck_enable;
    end

    // ---------------------------------------------------------------
    // sticky flags: set wins over write-one clear
    // ---------------------------------------------------------------
    logic flag_wr; // flag register written
    assign flag_wr = wr_take && avs_address == bfs_reg_flag_ofs;
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            uv_flag <= '0;
            ov_flag <= '0;
        end
        else
        begin
            // masks do not gate the flags
            uv_flag <= (uv_flag & ~(flag_wr && avs_byteenable[0] ? avs_writedata[2:0] : 3'h0)) | uv_ev;
            ov_flag <= (ov_flag & ~(flag_wr && avs_byteenable[1] ? avs_writedata[10:8] : 3'h0)) | ov_ev;
        end
    end

    // one request from every unmasked event, next cycle
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            powerdown_req <= 1'b0;
        else
            powerdown_req <= |((uv_ev & ~uv_mask) | (ov_ev & ~ov_mask));
    end

    // ---------------------------------------------------------------
    // register writes
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            host_en <= '0;
            lp_force <= '0;
            pmode <= {bfs_nbuck{bfs_mode_rst}};
            ramp_down_ctrl_enable <= 1'b1;
            uv_mask <= '0;
            ov_mask <= '0;
            discharge_disable <= '0; // discharge enabled at reset
            for (int k = 0; k < bfs_nbuck; k++)
            begin
                vout[k] <= bfs_vout_rst;
                seqc[k] <= 8'h00;
            end
        end
        else if (wr_take)
        begin
            case (avs_address)
                bfs_reg_ctrl_ofs:
                begin
                    host_en <= 3'(merge({29'h0, host_en}, avs_writedata, wmask));
                    lp_force <= 3'(merge({25'h0, lp_force, 4'h0}, avs_writedata, wmask) >> bfs_lp_force_lsb);
                end
                bfs_reg_mode_ofs:
                begin
                    pmode <= 6'(merge({26'h0, pmode}, avs_writedata, wmask));
                    if (avs_byteenable[1])
                        ramp_down_ctrl_enable <= avs_writedata[bfs_ramp_dn_bit];
                end
                bfs_reg_mask_ofs:
                begin
                    if (avs_byteenable[0])
                        uv_mask <= avs_writedata[2:0];
                    if (avs_byteenable[1])
                        ov_mask <= avs_writedata[10:8];
                end
                bfs_reg_dis_ofs:
                begin
                    if (avs_byteenable[0])
                        discharge_disable <= avs_writedata[2:0];
                end
                bfs_reg_vout_ofs, bfs_reg_seq_ofs:
                begin
                    // code write takes effect in one step
                    for (int k = 0; k < bfs_nbuck; k++)
                        if (avs_byteenable[k])
                        begin
                            if (avs_address == bfs_reg_vout_ofs)
                                vout[k] <= avs_writedata[k*8 +: 8];
                            else
                                seqc[k] <= avs_writedata[k*8 +: 8];
                        end
                end
                default:
                begin
                    // unmapped or read-only: write ignored
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // read data, registered, unmapped reads zero
    // ---------------------------------------------------------------
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            avs_readdata <= 32'h0;
        else if (avs_read && !ack)
        begin
            case (avs_address)
                bfs_reg_ctrl_ofs: avs_readdata <= {25'h0, lp_force, 1'b0, host_en};
                bfs_reg_mode_ofs: avs_readdata <= {23'h0, ramp_down_ctrl_enable, 2'h0, pmode};
                bfs_reg_mask_ofs: avs_readdata <= {21'h0, ov_mask, 5'h0, uv_mask};
                bfs_reg_flag_ofs: avs_readdata <= {21'h0, ov_flag, 5'h0, uv_flag};
                // live comparator status beside the flags
                bfs_reg_stat_ofs: avs_readdata <= {5'h0, discharge_on, 1'b0, buck_low_power,
                    1'b0, buck_enable, 1'b0, ilim_s, 1'b0, ov_s, 5'h0, uv_s};
                bfs_reg_seq_ofs: avs_readdata <= {8'h0, seqc[2], seqc[1], seqc[0]};
                bfs_reg_vout_ofs: avs_readdata <= {8'h0, vout[2], vout[1], vout[0]};
                bfs_reg_dis_ofs: avs_readdata <= {29'h0, discharge_disable};
                default: avs_readdata <= 32'h0;
            endcase
        end
    end

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    a_ov_ramp_hide: assert property (@(posedge clk) disable iff (!rstn)
        rd_busy[1] |-> !ov_ev[1])
        else $error("overvoltage seen during controlled ramp");
    a_ov_trip_pd: assert property (@(posedge clk) disable iff (!rstn)
        (ov_ev & ~ov_mask) != 3'h0 |=> powerdown_req)
        else $error("unmasked overvoltage gave no powerdown");
    a_uv_trip_pd: assert property (@(posedge clk) disable iff (!rstn)
        (uv_ev & ~uv_mask) != 3'h0 |=> powerdown_req)
        else $error("unmasked undervoltage gave no powerdown");
    a_uv_flag_set: assert property (@(posedge clk) disable iff (!rstn)
        uv_ev[1] |=> uv_flag[1])
        else $error("undervoltage flag not latched");
    a_mask_flag_set: assert property (@(posedge clk) disable iff (!rstn)
        ov_ev[1] && ov_mask[1] |=> ov_flag[1])
        else $error("masked overvoltage did not set flag");
    a_ss_blank_uv: assert property (@(posedge clk) disable iff (!rstn)
        ss_busy[1] |-> !uv_ev[1])
        else $error("undervoltage not blanked in soft-start");
    a_discharge_off: assert property (@(posedge clk) disable iff (!rstn)
        buck_enable != 3'h0 |-> (discharge_on & buck_enable) == 3'h0)
        else $error("discharge on while enabled");
    a_pd_quiet: assert property (@(posedge clk) disable iff (!rstn)
        ((uv_ev & ~uv_mask) | (ov_ev & ~ov_mask)) == 3'h0 |=> !powerdown_req)
        else $error("powerdown without cause");
    a_lp_forced: assert property (@(posedge clk) disable iff (!rstn)
        lp_force[1] |-> buck_low_power[1])
        else $error("forced low power ignored");
endmodule
`default_nettype wire

// *** tb/bfs_seq_model.sv ***
// sequencer model: drives the per-buck enables and drops them on a powerdown request
`timescale 1ns/1ps
`default_nettype none
module bfs_seq_model
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic [bfs_pkg::bfs_nbuck-1:0] want_en, // slots the bench asks to run
    input wire logic powerdown_req,
    output logic [bfs_pkg::bfs_nbuck-1:0] seq_enable
);
    import bfs_pkg::*;
    // ---------------------------------------------------------------
    // enable register
    // ---------------------------------------------------------------
    // a powerdown request wins, as a real sequencer shuts every slot
    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            seq_enable <= '0;
        else if (powerdown_req)
            seq_enable <= '0;
        else
            seq_enable <= want_en;
    end
endmodule
`default_nettype wire

// *** tb/test_bfs_top.sv ***
// testbench: registers, fault flags, blanking and mode control of the buck fault supervisor
`timescale 1ns/1ps
`default_nettype none
module test_bfs_top;
    import bfs_pkg::*;
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] avs_address = 8'h00;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic [2:0] uv_cmp = 3'h0; // comparator levels, bit k is buck k
    logic [2:0] ov_cmp = 3'h0;
    logic [2:0] ilim_cmp = 3'h0;
    logic [2:0] want_en = 3'h0;
    logic [2:0] seq_enable;
    logic deep_sleep_state = 1'b0;
    logic powerdown_req;
    logic [2:0] buck_enable, buck_low_power, discharge_on;
    logic [23:0] buck_voltage_code, buck_sequencer_config;
    logic [65:0] buck_target_uv;
    logic [31:0] q; // last read data
    int n_errors = 0;
    int samples_checked = 0;
    initial
    begin
        forever #2.5 clk = ~clk;
    end
    // short ramp window keeps the ramp tests quick
    bfs_top #(.ramp_cycles(20)) u_dut (.clk(clk), .rstn(rstn), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hf), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .uv_cmp(uv_cmp), .ov_cmp(ov_cmp), .ilim_cmp(ilim_cmp), .seq_enable(seq_enable),
        .deep_sleep_state(deep_sleep_state), .powerdown_req(powerdown_req), .buck_enable(buck_enable),
        .buck_low_power(buck_low_power), .discharge_on(discharge_on), .buck_voltage_code(buck_voltage_code),
        .buck_sequencer_config(buck_sequencer_config), .buck_target_uv(buck_target_uv));
    bfs_seq_model u_seq (.clk(clk), .rstn(rstn), .want_en(want_en), .powerdown_req(powerdown_req),
        .seq_enable(seq_enable));
    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    // request stands until waitrequest is sampled low at a rising edge; one more edge lets results settle
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= w;
        avs_read <= ~w;
        do
            @(posedge clk);
        while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic complete_run();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic s_reset();
        bus(0, bfs_reg_mode_ofs, 0);
        chk("mode", q, 32'h115);
        chk("dis", discharge_on, 3'h7);
        bus(0, 8'h20, 32'hffff_ffff);
        chk("unmapped", q, 32'h0);
    endtask
    task automatic s_codes();
        bus(1, bfs_reg_vout_ofs, 32'h00ff_ff00);
        chk("codes", buck_voltage_code, 24'hffff00);
        chk("b2max", buck_target_uv[43:22], bfs_vmin_uv + bfs_step2_uv * 255);
        chk("b3max", buck_target_uv[65:44], bfs_vmin_uv + bfs_step3_uv * 255);
        bus(1, bfs_reg_vout_ofs, 32'h0);
        chk("b2min", buck_target_uv[43:22], bfs_vmin_uv);
    endtask
    task automatic s_seq();
        bus(1, bfs_reg_seq_ofs, 32'h0093_0000);
        chk("seqcfg", buck_sequencer_config[23:16], 8'h93);
        want_en <= 3'h4;
        repeat (5) @(posedge clk);
        chk("seqen", buck_enable, 3'h4);
        chk("disen", discharge_on, 3'h3);
        want_en <= 3'h0;
        repeat (4) @(posedge clk);
        bus(1, bfs_reg_dis_ofs, 32'h1);
        chk("disoff", discharge_on, 3'h6);
    endtask
    // faults present from enable on stay hidden 100 cycles into soft-start, then latch once it ends
    task automatic s_uv();
        uv_cmp <= 3'h2;
        ov_cmp <= 3'h2;
        ilim_cmp <= 3'h2;
        bus(1, bfs_reg_ctrl_ofs, 32'h2);
        chk("hosten", buck_enable, 3'h2);
        repeat (100) @(posedge clk);
        bus(0, bfs_reg_flag_ofs, 0);
        chk("ssblank", q, 32'h0);
        repeat (7100) @(posedge clk);
        bus(0, bfs_reg_flag_ofs, 0);
        chk("flags", q, 32'h202);
        chk("pdreq", powerdown_req, 1'b1);
        bus(0, bfs_reg_stat_ofs, 0);
        chk("live", q & 32'h7707, 32'h2202);
        bus(1, bfs_reg_mask_ofs, 32'h202);
        bus(1, bfs_reg_flag_ofs, 32'h202);
        bus(0, bfs_reg_flag_ofs, 0);
        chk("mflags", q, 32'h202);
        chk("mpdreq", powerdown_req, 1'b0);
        uv_cmp <= 3'h0;
        ov_cmp <= 3'h0;
        ilim_cmp <= 3'h0;
        repeat (4) @(posedge clk);
        bus(1, bfs_reg_flag_ofs, 32'h202);
        bus(1, bfs_reg_mask_ofs, 32'h0);
    endtask
    task automatic s_ov();
        bus(1, bfs_reg_vout_ofs, 32'h4000);
        uv_cmp <= 3'h2;
        repeat (5) @(posedge clk);
        chk("raise", powerdown_req, 1'b1);
        uv_cmp <= 3'h0;
        repeat (4) @(posedge clk);
        bus(1, bfs_reg_flag_ofs, 32'h2);
        chk("idle", powerdown_req, 1'b0);
        bus(1, bfs_reg_vout_ofs, 32'h1000);
        ov_cmp <= 3'h2;
        bus(0, bfs_reg_flag_ofs, 0);
        chk("rampblank", q, 32'h0);
        repeat (30) @(posedge clk);
        bus(0, bfs_reg_flag_ofs, 0);
        chk("ovflag", q, 32'h200);
        chk("ovreq", powerdown_req, 1'b1);
        ov_cmp <= 3'h0;
        repeat (4) @(posedge clk);
        bus(1, bfs_reg_flag_ofs, 32'h200);
        bus(1, bfs_reg_mode_ofs, 32'h15);
        bus(1, bfs_reg_vout_ofs, 32'h0800);
        ov_cmp <= 3'h2;
        repeat (5) @(posedge clk);
        chk("noramp", powerdown_req, 1'b1);
        bus(1, bfs_reg_mask_ofs, 32'h200);
        @(posedge clk);
        chk("masked", powerdown_req, 1'b0);
        ov_cmp <= 3'h0;
        repeat (4) @(posedge clk);
        bus(1, bfs_reg_flag_ofs, 32'h200);
        // masks first, then a one-step raise trips nothing
        bus(1, bfs_reg_mask_ofs, 32'h202);
        bus(1, bfs_reg_vout_ofs, 32'h2000);
        uv_cmp <= 3'h2;
        repeat (5) @(posedge clk);
        chk("maskraise", powerdown_req, 1'b0);
        uv_cmp <= 3'h0;
        repeat (4) @(posedge clk);
        bus(1, bfs_reg_flag_ofs, 32'h2);
    endtask
    task automatic s_mode();
        bus(1, bfs_reg_mode_ofs, 32'h1d);
        chk("lp", buck_low_power, 3'h2);
        bus(1, bfs_reg_mode_ofs, 32'h19);
        chk("awake", buck_low_power, 3'h0);
        deep_sleep_state <= 1'b1;
        repeat (4) @(posedge clk);
        chk("asleep", buck_low_power, 3'h2);
        deep_sleep_state <= 1'b0;
        bus(1, bfs_reg_mode_ofs, 32'h15);
        bus(1, bfs_reg_ctrl_ofs, 32'h22);
        chk("forced", buck_low_power, 3'h2);
    endtask
    initial
    begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        s_reset();
        s_codes();
        s_seq();
        s_uv();
        s_ov();
        s_mode();
        complete_run();
    end
    // watchdog: the tests need about 7500 cycles
    initial
    begin
        repeat (40000) @(posedge clk);
        n_errors++;
        complete_run();
    end
endmodule
`default_nettype wire
